// File: logic/rl_pkg.sv
package rl_pkg;
  // clock and refill timing
  localparam int unsigned CLK_MHZ      = 50;
  localparam int unsigned TICK_US      = 1000;
  localparam int unsigned TICK_CYC     = TICK_US * CLK_MHZ;
  localparam int unsigned TICK_W       = 16;

  // register indices, byte address is four times the index
  localparam logic [9:0]  IDX_ING_LO   = 10'h074;
  localparam logic [9:0]  IDX_ING_HI   = 10'h076;
  localparam logic [9:0]  IDX_EG_LO    = 10'h078;
  localparam logic [9:0]  IDX_CTRL     = 10'h080;
  localparam logic [9:0]  IDX_STAT     = 10'h081;
  localparam int unsigned ADDR_W       = 12;

  // code fields
  localparam int unsigned CODE_W       = 7;
  localparam int unsigned HI_LSB       = 8;
  localparam int unsigned LO_LSB       = 0;
  localparam logic [15:0] CODE_MASK    = 16'h7f7f;
  localparam logic [15:0] CODE_RST     = 16'h0000;

  // rate code table
  localparam logic [6:0]  MBPS_MAX_100 = 7'h64;
  localparam logic [6:0]  MBPS_MAX_10  = 7'h0a;
  localparam logic [6:0]  KBPS_FIRST   = 7'h65;
  localparam logic [6:0]  KBPS_LAST    = 7'h73;
  localparam logic [6:0]  KBPS_BASE    = 7'h64;
  localparam logic [13:0] BYTES_MBPS   = 14'h007d;
  localparam logic [13:0] BYTES_64K    = 14'h0008;
  localparam logic [15:0] CREDIT_CAP   = 16'h4000;

  // per-frame overhead
  localparam logic [15:0] IFG_BYTES    = 16'h000c;
  localparam logic [15:0] PRE_BYTES    = 16'h0008;

  // control register layout
  localparam int unsigned CTRL_SPEED   = 0;
  localparam int unsigned CTRL_QUE_LSB = 1;
  localparam int unsigned CTRL_MOD_LSB = 3;
  localparam int unsigned CTRL_IFG     = 5;
  localparam int unsigned CTRL_PRE     = 6;
  localparam logic [15:0] CTRL_MASK    = 16'h007f;
  localparam logic [15:0] CTRL_RST     = 16'h0001;
  localparam logic [1:0]  QUE_ONE      = 2'h0;
  localparam logic [1:0]  QUE_TWO      = 2'h1;

  // status register layout
  localparam int unsigned STAT_FULL    = 0;
  localparam int unsigned STAT_HOLD    = 1;
  localparam int unsigned STAT_DROP_LSB = 8;

  // frame descriptor layout
  localparam int unsigned DESC_W       = 16;
  localparam int unsigned LEN_LSB      = 0;
  localparam int unsigned LEN_W        = 11;
  localparam int unsigned PRIO_LSB     = 11;
  localparam int unsigned TYPE_LSB     = 13;
  localparam int unsigned DIR_BIT      = 15;
  localparam logic [1:0]  TYPE_BCAST   = 2'h3;

  localparam int unsigned FIFO_DEPTH   = 4;
  localparam int unsigned NB           = 6;
  localparam logic [2:0]  EG_BASE      = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } lim_state_e;
endpackage

// File: logic/rl_fifo_if.sv
interface rl_fifo_if #(parameter int WIDTH = 16);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo_mp (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user_mp (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

// File: logic/rl_fifo.sv
module rl_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  rl_fifo_if.fifo_mp f
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp_r;
  logic [AW-1:0]    rp_r;
  logic [AW:0]      cnt_r;
  logic [AW:0]      cnt_nxt;
  logic             rdy_r;
  wire              push = f.in_valid & rdy_r;
  wire              pop  = f.out_ready & (cnt_r != '0);

  assign cnt_nxt     = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  assign f.in_ready  = rdy_r;
  assign f.out_valid = cnt_r != '0;
  assign f.out_data  = mem[rp_r];

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end else begin
      wp_r  <= wp_r + AW'(push);
      rp_r  <= rp_r + AW'(pop);
      cnt_r <= cnt_nxt;
      rdy_r <= cnt_nxt != (AW+1)'(DEPTH);
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_r] <= f.in_data;
    end
  end
endmodule // rl_fifo

// File: logic/port_rate_limiter.sv
// Decided for this implementation: the APB slave port.
module port_rate_limiter #(
  parameter int unsigned TICK_CYCLES = rl_pkg::TICK_CYC
) (
  input  wire logic                        MCLK_I,
  input  wire logic                        ARST_N_I,
  input  wire logic                        PSEL_I,
  input  wire logic                        PENABLE_I,
  input  wire logic                        PWRITE_I,
  input  wire logic [rl_pkg::ADDR_W-1:0]   PADDR_I,
  input  wire logic [31:0]                 PWDATA_I,
  output logic      [31:0]                 PRDATA_O,
  output logic                             PREADY_O,
  output logic                             PSLVERR_O,
  input  wire logic                        FRM_VALID_I,
  input  wire logic [rl_pkg::DESC_W-1:0]   FRM_DATA_I,
  output logic                             FRM_READY_O,
  output logic                             RES_VALID_O,
  output logic                             RES_PASS_O,
  output logic      [rl_pkg::DESC_W-1:0]   RES_DATA_O
);
  localparam int unsigned TICK_W_L = rl_pkg::TICK_W;
  typedef rl_pkg::lim_state_e lim_state_q_t;

  rl_fifo_if #(.WIDTH(rl_pkg::DESC_W)) q ();

  logic [15:0]         ing_lo_r;
  logic [15:0]         ing_hi_r;
  logic [15:0]         eg_lo_r;
  logic [15:0]         ctrl_r;
  logic [7:0]          drop_cnt_r;
  logic                pready_r;
  logic                pslverr_r;
  logic [31:0]         prdata_r;
  logic                res_valid_r;
  logic                res_pass_r;
  logic [15:0]         res_data_r;
  logic                frm_ready_r;
  logic [TICK_W_L-1:0] tick_cnt_r;
  lim_state_q_t        state_r;
  lim_state_q_t        state_nxt;
  logic [15:0]         credit_r [rl_pkg::NB];
  logic [6:0]          codes    [rl_pkg::NB];
  logic [13:0]         add_w    [rl_pkg::NB];
  logic [rl_pkg::NB-1:0] limited;
  logic [rl_pkg::NB-1:0] charge;

  rl_fifo #(.WIDTH(rl_pkg::DESC_W), .DEPTH(rl_pkg::FIFO_DEPTH)) u_fifo (
    .clk_i    (MCLK_I),
    .arst_n_i (ARST_N_I),
    .f        (q.fifo_mp)
  );
  assign q.in_valid = FRM_VALID_I;
  assign q.in_data  = FRM_DATA_I;

  // apb decode
  wire [9:0] idx      = PADDR_I[rl_pkg::ADDR_W-1:2];
  wire       aligned  = PADDR_I[1:0] == 2'h0;
  wire       sel_ilo  = aligned & (idx == rl_pkg::IDX_ING_LO);
  wire       sel_ihi  = aligned & (idx == rl_pkg::IDX_ING_HI);
  wire       sel_elo  = aligned & (idx == rl_pkg::IDX_EG_LO);
  wire       sel_ctl  = aligned & (idx == rl_pkg::IDX_CTRL);
  wire       sel_st   = aligned & (idx == rl_pkg::IDX_STAT);
  wire       mapped   = sel_ilo | sel_ihi | sel_elo | sel_ctl | sel_st;
  wire       acc      = PSEL_I & PENABLE_I & pready_r;
  wire       wr_en    = acc & PWRITE_I;
  wire       holding  = state_r == rl_pkg::ST_HOLD;
  wire [15:0] stat_w  = {drop_cnt_r, 6'h00, holding, ~frm_ready_r};
  wire [15:0] rd_mux  = sel_ilo ? ing_lo_r : sel_ihi ? ing_hi_r : sel_elo ? eg_lo_r :
                        sel_ctl ? ctrl_r : sel_st ? stat_w : 16'h0000;

  // control fields
  wire       speed100 = ctrl_r[rl_pkg::CTRL_SPEED];
  wire [1:0] que      = ctrl_r[rl_pkg::CTRL_QUE_LSB +: 2];
  wire [1:0] mode     = ctrl_r[rl_pkg::CTRL_MOD_LSB +: 2];
  wire       ifg_on   = ctrl_r[rl_pkg::CTRL_IFG];
  wire       pre_on   = ctrl_r[rl_pkg::CTRL_PRE];
  wire       tick     = tick_cnt_r == TICK_W_L'(TICK_CYCLES - 1);

  assign codes[0] = ing_lo_r[rl_pkg::LO_LSB +: rl_pkg::CODE_W];
  assign codes[1] = ing_lo_r[rl_pkg::HI_LSB +: rl_pkg::CODE_W];
  assign codes[2] = ing_hi_r[rl_pkg::LO_LSB +: rl_pkg::CODE_W];
  assign codes[3] = ing_hi_r[rl_pkg::HI_LSB +: rl_pkg::CODE_W];
  assign codes[4] = eg_lo_r[rl_pkg::LO_LSB +: rl_pkg::CODE_W];
  assign codes[5] = eg_lo_r[rl_pkg::HI_LSB +: rl_pkg::CODE_W];

  // head descriptor
  wire [15:0] hd      = q.out_data;
  wire [15:0] hlen    = {5'h00, hd[rl_pkg::LEN_LSB +: rl_pkg::LEN_W]};
  wire [1:0]  hprio   = hd[rl_pkg::PRIO_LSB +: 2];
  wire [1:0]  htype   = hd[rl_pkg::TYPE_LSB +: 2];
  wire        hegr    = hd[rl_pkg::DIR_BIT];
  wire [15:0] cost    = hlen + (ifg_on ? rl_pkg::IFG_BYTES : 16'h0000)
                             + (pre_on ? rl_pkg::PRE_BYTES : 16'h0000);
  wire [2:0]  hidx    = hegr ? (rl_pkg::EG_BASE + {2'h0, hprio[0]}) : {1'b0, hprio};
  wire        eg_app  = (que == rl_pkg::QUE_ONE) ? (hprio == 2'h0) :
                        (que == rl_pkg::QUE_TWO) ? (hprio <= 2'h1) :
                        1'b0;
  wire        applied = hegr ? eg_app : (htype >= mode);
  wire        head_lim = applied & limited[hidx];
  wire        credit_ok = credit_r[hidx] >= cost;
  wire        pass_now = q.out_valid & (~head_lim | credit_ok);
  wire        drop_now = q.out_valid & head_lim & ~credit_ok & ~hegr;
  wire        hold_now = q.out_valid & head_lim & ~credit_ok & hegr;
  assign q.out_ready = pass_now | drop_now;

  // per-bucket rate decode and credit
  for (genvar b = 0; b < rl_pkg::NB; b++) begin : g_bucket
    wire [6:0]  code    = codes[b];
    wire [6:0]  mb_max  = speed100 ? rl_pkg::MBPS_MAX_100 : rl_pkg::MBPS_MAX_10;
    wire        mbps_ok = (code != 7'h00) & (code <= mb_max);
    wire        kbps_ok = (code >= rl_pkg::KBPS_FIRST) & (code <= rl_pkg::KBPS_LAST);
    wire [6:0]  ksteps  = code - rl_pkg::KBPS_BASE;
    wire [16:0] sum     = {1'b0, credit_r[b]} + {3'h0, (tick ? add_w[b] : 14'h0000)};
    wire [15:0] capped  = (sum > {1'b0, rl_pkg::CREDIT_CAP}) ? rl_pkg::CREDIT_CAP : sum[15:0];
    assign limited[b] = mbps_ok | kbps_ok;
    assign add_w[b]   = mbps_ok ? 14'({7'h00, code} * rl_pkg::BYTES_MBPS) :
                        kbps_ok ? 14'({7'h00, ksteps} * rl_pkg::BYTES_64K) :
                        14'h0000;
    assign charge[b]  = pass_now & head_lim & (hidx == 3'(b));
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        credit_r[b] <= rl_pkg::CREDIT_CAP;
      end else begin
        credit_r[b] <= capped - (charge[b] ? cost : 16'h0000);
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rl_pkg::ST_IDLE: begin
        if (hold_now) begin
          state_nxt = rl_pkg::ST_HOLD;
        end
      end
      rl_pkg::ST_HOLD: begin
        if (pass_now) begin
          state_nxt = rl_pkg::ST_IDLE;
        end
      end
      default: state_nxt = rl_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ing_lo_r <= rl_pkg::CODE_RST;
      ing_hi_r <= rl_pkg::CODE_RST;
      eg_lo_r  <= rl_pkg::CODE_RST;
      ctrl_r   <= rl_pkg::CTRL_RST;
    end else if (wr_en) begin
      if (sel_ilo) ing_lo_r <= PWDATA_I[15:0] & rl_pkg::CODE_MASK;
      if (sel_ihi) ing_hi_r <= PWDATA_I[15:0] & rl_pkg::CODE_MASK;
      if (sel_elo) eg_lo_r  <= PWDATA_I[15:0] & rl_pkg::CODE_MASK;
      if (sel_ctl) ctrl_r   <= PWDATA_I[15:0] & rl_pkg::CTRL_MASK;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= PSEL_I & PENABLE_I & ~pready_r;
      pslverr_r <= PSEL_I & PENABLE_I & ~pready_r & ~mapped;
      prdata_r  <= (PSEL_I & PENABLE_I & ~pready_r & ~PWRITE_I) ? {16'h0000, rd_mux}
                                                              : 32'h0000_0000;
    end
  end

  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tick_cnt_r  <= '0;
      state_r     <= rl_pkg::ST_IDLE;
      res_valid_r <= 1'b0;
      res_pass_r  <= 1'b0;
      res_data_r  <= 16'h0000;
      drop_cnt_r  <= 8'h00;
      frm_ready_r <= 1'b0;
    end else begin
      tick_cnt_r  <= tick ? '0 : tick_cnt_r + 1'b1;
      state_r     <= state_nxt;
      res_valid_r <= pass_now | drop_now;
      res_pass_r  <= pass_now;
      res_data_r  <= q.out_ready ? hd : res_data_r;
      drop_cnt_r  <= drop_cnt_r + 8'(drop_now);
      frm_ready_r <= q.in_ready;
    end
  end

  assign PRDATA_O    = prdata_r;
  assign PREADY_O    = pready_r;
  assign PSLVERR_O   = pslverr_r;
  assign RES_VALID_O = res_valid_r;
  assign RES_PASS_O  = res_pass_r;
  assign RES_DATA_O  = res_data_r;
  assign FRM_READY_O = q.in_ready;

  // checks
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);

  sequence s_apb_access;
    PSEL_I & PENABLE_I & ~pready_r;
  endsequence
  property p_apb_ready;
    s_apb_access |=> pready_r;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb answer late");

  sequence s_wr_ilo;
    wr_en & sel_ilo;
  endsequence
  property p_ing_lo;
    s_wr_ilo |=> (codes[1] == $past(PWDATA_I[14:8])) && (codes[0] == $past(PWDATA_I[6:0]));
  endproperty
  a_ing_lo: assert property (p_ing_lo) else $error("ingress low codes wrong");

  property p_ing_hi;
    wr_en & sel_ihi |=> (codes[3] == $past(PWDATA_I[14:8])) && (codes[2] == $past(PWDATA_I[6:0]));
  endproperty
  a_ing_hi: assert property (p_ing_hi) else $error("ingress high codes wrong");

  property p_eg_lo;
    wr_en & sel_elo |=> (codes[5] == $past(PWDATA_I[14:8])) && (codes[4] == $past(PWDATA_I[6:0]));
  endproperty
  a_eg_lo: assert property (p_eg_lo) else $error("egress codes wrong");

  property p_zero_free;
    q.out_valid & ~hegr & (codes[hidx] == 7'h00) |=> res_valid_r & res_pass_r;
  endproperty
  a_zero_free: assert property (p_zero_free) else $error("zero code limited");

  property p_rate_100;
    speed100 & (codes[0] == 7'h01) |-> limited[0] && (add_w[0] == 14'h007d);
  endproperty
  a_rate_100: assert property (p_rate_100) else $error("100 Mbps refill wrong");

  property p_rate_10;
    ~speed100 & (codes[3] == 7'h0a) |-> limited[3] && (add_w[3] == 14'h04e2);
  endproperty
  a_rate_10: assert property (p_rate_10) else $error("10 Mbps refill wrong");

  property p_rate_kbps;
    (codes[2] == 7'h65) |-> limited[2] && (add_w[2] == 14'h0008);
  endproperty
  a_rate_kbps: assert property (p_rate_kbps) else $error("Kbps refill wrong");

  property p_drop_ingress;
    res_valid_r & ~res_pass_r |-> ~res_data_r[rl_pkg::DIR_BIT] && $past(head_lim);
  endproperty
  a_drop_ingress: assert property (p_drop_ingress) else $error("bad drop");

  property p_one_queue;
    q.out_valid & hegr & (que == rl_pkg::QUE_ONE) & (hprio != 2'h0) |=> res_valid_r & res_pass_r;
  endproperty
  a_one_queue: assert property (p_one_queue) else $error("egress limit misapplied");

  property p_two_queue;
    q.out_valid & hegr & (que == rl_pkg::QUE_TWO) & (hprio == 2'h1) & limited[5] &
      (credit_r[5] < cost) |=> ~res_valid_r && holding;
  endproperty
  a_two_queue: assert property (p_two_queue) else $error("prio1 egress not held");

  property p_bcast_mode;
    q.out_valid & ~hegr & (mode == 2'h3) & (htype != rl_pkg::TYPE_BCAST) |=> res_pass_r;
  endproperty
  a_bcast_mode: assert property (p_bcast_mode) else $error("uncounted frame limited");

  property p_cost;
    ifg_on & pre_on |-> cost == hlen + 16'h0014;
  endproperty
  a_cost: assert property (p_cost) else $error("overhead bytes wrong");

  property p_undef_code;
    ~speed100 & (codes[2] == 7'h0b) |-> ~limited[2];
  endproperty
  a_undef_code: assert property (p_undef_code) else $error("undefined code limits");
endmodule // port_rate_limiter

// File: tb/tb_port_rate_limiter.sv
module tb_port_rate_limiter;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A_IL = {rl_pkg::IDX_ING_LO, 2'b00};
  localparam logic [11:0] A_IH = {rl_pkg::IDX_ING_HI, 2'b00};
  localparam logic [11:0] A_EL = {rl_pkg::IDX_EG_LO, 2'b00};
  localparam logic [11:0] A_CT = {rl_pkg::IDX_CTRL, 2'b00};
  localparam logic [11:0] A_ST = {rl_pkg::IDX_STAT, 2'b00};
  logic        mclk;
  logic        arst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        frm_valid;
  logic [15:0] frm_data;
  logic        frm_ready;
  logic        res_valid;
  logic        res_pass;
  logic [15:0] res_data;
  logic [31:0] rd;
  logic        er;
  int          bad_count;
  int          n_tests;
  int          pushed;
  logic        pass_q[$];
  logic [15:0] data_q[$];
  // register table rows: address, write data, read back, error flag
  logic [11:0] row_a [6] = '{A_IL, A_IH, A_EL, 12'h100, 12'h1d2, A_ST};
  logic [31:0] row_w [6] = '{32'h0000_ffff, 32'h1234_5678, 32'h0000_8080,
                             32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff};
  logic [31:0] row_e [6] = '{32'h0000_7f7f, 32'h0000_5678, 32'h0000_0000,
                             32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  logic        row_s [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [11:0] rst_a [5] = '{A_IL, A_IH, A_EL, A_CT, A_ST};

  port_rate_limiter #(.TICK_CYCLES(50)) u_port_rate_limiter (
    .MCLK_I(mclk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable),
    .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .FRM_VALID_I(frm_valid),
    .FRM_DATA_I(frm_data), .FRM_READY_O(frm_ready), .RES_VALID_O(res_valid),
    .RES_PASS_O(res_pass), .RES_DATA_O(res_data)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // result capture
  always @(posedge mclk) begin
    if (res_valid === 1'b1) begin
      pass_q.push_back(res_pass);
      data_q.push_back(res_data);
    end
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic tmo;
    bad_count++;
    $display("Error t=%0t wait limit", $time);
    print_verdict();
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) tmo();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk_reg(rd, exp);
  endtask

  function automatic logic [15:0] mk(logic e, logic [1:0] t, logic [1:0] p, logic [10:0] n);
    return {e, t, p, n};
  endfunction

  task automatic push(input logic [15:0] d, input int n);
    int k;
    frm_valid <= 1'b1;
    frm_data <= d;
    for (int j = 0; j < n; j++) begin
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (frm_ready !== 1'b1 && k < 100);
      if (frm_ready !== 1'b1) tmo();
    end
    frm_valid <= 1'b0;
  endtask

  task automatic exp_res(input logic [15:0] d, input int n, input int npass);
    int k;
    for (int j = 0; j < n; j++) begin
      k = 0;
      while (pass_q.size() == 0 && k < 200) begin
        @(posedge mclk);
        k++;
      end
      if (pass_q.size() == 0) tmo();
      chk_bit(pass_q.pop_front(), 1'(j < npass));
      chk_reg({16'h0000, data_q.pop_front()}, {16'h0000, d});
    end
  endtask

  initial begin
    arst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    frm_valid = 1'b0;
    frm_data = 16'h0000;
    bad_count = 0;
    n_tests = 0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, row_a[i], row_w[i]);
      rdchk(row_a[i], row_e[i]);
      chk_bit(er, row_s[i]);
    end
    apb(1'b1, A_IH, 32'h0000_0000);
    apb(1'b1, A_IL, 32'h0000_0001);
    push(mk(0, 0, 0, 11'h7ff), 9);
    exp_res(mk(0, 0, 0, 11'h7ff), 9, 8);
    rdchk(A_ST, 32'h0000_0100);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, A_CT, 32'h0000_0001 | 32'(m << 3));
      for (int t = 0; t < 4; t++) begin
        push(mk(0, 2'(t), 0, 11'h7ff), 1);
        exp_res(mk(0, 2'(t), 0, 11'h7ff), 1, int'(t < m));
      end
    end
    apb(1'b1, A_CT, 32'h0000_0000);
    push(mk(0, 0, 1, 11'h7ff), 9);
    exp_res(mk(0, 0, 1, 11'h7ff), 9, 9);
    apb(1'b1, A_IH, 32'h0000_0a0b);
    push(mk(0, 0, 2, 11'h7ff), 9);
    exp_res(mk(0, 0, 2, 11'h7ff), 9, 9);
    push(mk(0, 0, 3, 11'h7ff), 9);
    exp_res(mk(0, 0, 3, 11'h7ff), 9, 8);
    apb(1'b1, A_CT, 32'h0000_0021);
    apb(1'b1, A_IH, 32'h0000_0065);
    push(mk(0, 0, 2, 11'h7f8), 8);
    exp_res(mk(0, 0, 2, 11'h7f8), 8, 7);
    apb(1'b1, A_CT, 32'h0000_0041);
    apb(1'b1, A_IL, 32'h0000_6500);
    push(mk(0, 0, 1, 11'h7fa), 9);
    exp_res(mk(0, 0, 1, 11'h7fa), 9, 7);
    apb(1'b1, A_CT, 32'h0000_0001);
    apb(1'b1, A_EL, 32'h0000_6500);
    push(mk(1, 0, 1, 11'h7ff), 9);
    exp_res(mk(1, 0, 1, 11'h7ff), 9, 9);
    apb(1'b1, A_CT, 32'h0000_0003);
    push(mk(1, 0, 1, 11'h7ff), 9);
    exp_res(mk(1, 0, 1, 11'h7ff), 8, 8);
    repeat (40) @(posedge mclk);
    chk_reg(32'(pass_q.size()), 32'h0000_0000);
    rdchk(A_ST, 32'h0000_0f02);
    // fill the buffer behind the held head until it refuses
    pushed = 0;
    frm_valid <= 1'b1;
    do begin
      @(posedge mclk);
      if (frm_ready === 1'b1) pushed++;
    end while (frm_ready === 1'b1 && pushed < 10);
    frm_valid <= 1'b0;
    chk_bit(1'(pushed < 10), 1'b1);
    rdchk(A_ST, 32'h0000_0f03);
    apb(1'b1, A_EL, 32'h0000_0000);
    exp_res(mk(1, 0, 1, 11'h7ff), pushed + 1, pushed + 1);
    arst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 5; i++) begin
      rdchk(rst_a[i], 32'(rst_a[i] == A_CT));
    end
    print_verdict();
  end
endmodule // tb_port_rate_limiter
